// [vgah_pkg.sv]
// constants shared by both ends of the horizontal display timing controller
// assumes one system clock; character clock is an enable from a divider
package vgah_pkg;
  // i/o port addresses, picked by the emulation select bit
  localparam logic [15:0] IO_IDX_MONO = 16'h03B4;
  localparam logic [15:0] IO_DAT_MONO = 16'h03B5;
  localparam logic [15:0] IO_IDX_COLOR = 16'h03D4;
  localparam logic [15:0] IO_DAT_COLOR = 16'h03D5;
  // timing register indices
  localparam logic [6:0] IX_HTOTAL = 7'h00;
  localparam logic [6:0] IX_HACT_END = 7'h01;
  localparam logic [6:0] IX_HBLK_START = 7'h02;
  localparam logic [6:0] IX_HBLK_END = 7'h03;
  localparam logic [6:0] IX_HSYNC_START = 7'h04;
  localparam logic [6:0] IX_HSYNC_END = 7'h05;
  localparam logic [6:0] IX_PROT_LAST = 7'h07;
  // reset values
  localparam logic [7:0] HTOTAL_RST = 8'h00;
  localparam logic [7:0] HSYNC_END_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [6:0] IDX_RST = 7'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // field layout
  localparam int BE_MSB_BIT = 7;
  localparam int SKEW_HI = 6;
  localparam int SKEW_LO = 5;
  localparam int BE_LOW_HI = 4;
  localparam int SE_HI = 4;
  localparam int BE_W = 6;
  localparam int SE_W = 5;
  localparam logic [7:0] RSVD_ONE = 8'h80;
  // programmed total is chars minus five; last count is that plus four
  localparam logic [8:0] HTOTAL_LAST_BIAS = 9'h004;
  localparam int CHAR_DIV_DEF = 1;
  // controller register map (axi4-lite, byte addresses)
  localparam logic [7:0] HR_CTRL = 8'h00;
  localparam logic [7:0] HR_ADDR = 8'h04;
  localparam logic [7:0] HR_WDATA = 8'h08;
  localparam logic [7:0] HR_READ = 8'h0C;
  localparam logic [7:0] HR_STAT = 8'h10;
  localparam int CTL_COLOR = 0;
  localparam int CTL_PROT = 1;
  localparam int CTL_VACT = 2;
  localparam int ST_BUSY = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    VGAH_IDLE = 3'b001,
    VGAH_REQ = 3'b010,
    VGAH_WAIT = 3'b100
  } vgah_io_state_e;
endpackage

// [vgah_if.sv]
// byte-wide i/o port between controller and timing device
// assumes both ends run on the same clock; strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface vgah_if;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_ack;
  logic color_sel;
  logic protect;
  logic vactive;
  modport dev (
    input io_addr, io_wr, io_rd, io_wdata, color_sel, protect, vactive,
    output io_rdata, io_ack
  );
  modport host (
    output io_addr, io_wr, io_rd, io_wdata, color_sel, protect, vactive,
    input io_rdata, io_ack
  );
endinterface
`default_nettype wire

// [vgah_dly.sv]
// selectable 0..3 character clock delay with one fixed register stage
// assumes ce is a one-cycle character clock enable
`timescale 1ns/1ps
`default_nettype none
module vgah_dly (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // character clock enable
  input wire logic d, // undelayed signal
  input wire logic [1:0] sel, // extra delay in characters
  output logic q // delayed signal
);
  logic [2:0] sh_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= 3'h0;
    end else if (ce) begin
      sh_r <= {sh_r[1:0], d};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (ce) begin
      q <= (sel == 2'h0) ? d : sh_r[sel - 2'h1];
    end
  end
endmodule
`default_nettype wire

// [vgah_dev.sv]
// horizontal display timing device: index/data register pair plus
// character counter, display enable, blanking and sync generation
// assumes the controller holds each strobe for one cycle only
// Behaviour
// [RULE1] index port at mono or color address
// [RULE2] data port at mono or color address
// [RULE3] seven-bit index, top bit reads zero
// [RULE4] protect bit blocks writes to indices 0-7
// [RULE5] total field is line chars minus five
// [RULE6] zero total stops display data fetch
// [RULE7] active end field is active chars minus one
// [RULE8] enable on at line start, off at end
// [RULE9] oversized active end drops only last char
// [RULE10] blanking starts at blank start count
// [RULE11] blank end bit 7 reads one always
// [RULE12] skew delays enable by 0-3 chars
// [RULE13] blank ends on six-bit counter match
// [RULE14] sync end bit 7 is blank end bit 5
// [RULE15] software sets blank end start plus length
// [RULE16] sync starts at sync start count
// [RULE17] software keeps sync inside blanking margins
// [RULE18] sync delay shifts sync by 0-3 chars
// [RULE19] sync ends on five-bit counter match
// [RULE20] counter wraps to zero after line total
// [RULE21] data reads return stored register contents
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module vgah_dev #(
  parameter int CHAR_DIV = vgah_pkg::CHAR_DIV_DEF
) (
  input wire logic CLK, // system clock, 20 mhz
  input wire logic RST_N, // async reset, active low
  vgah_if.dev IO, // register port from the controller
  output var logic HDE, // horizontal display enable
  output var logic HBLANK, // horizontal blanking
  output var logic HSYNC, // horizontal sync, active high
  output var logic FETCH_EN // display data fetch allowed
);
  import vgah_pkg::*;

  localparam logic [7:0] DIV_LAST = 8'(CHAR_DIV - 1);

  logic [6:0] idx_r;
  logic [7:0] htotal_r;
  logic [7:0] hact_end_r;
  logic [7:0] hblk_start_r;
  logic [6:0] hblk_end_r;
  logic [7:0] hsync_start_r;
  logic [7:0] hsync_end_r;
  logic [7:0] div_r;
  logic ce_r;
  logic [8:0] cnt_r;
  logic blank_r;
  logic sync_r;
  logic de_raw;
  logic de_r;
  logic [8:0] cnt_last;
  logic idx_hit;
  logic dat_hit;
  logic wr_ok;
  logic [BE_W-1:0] blk_end6;

  // port match for the emulation chosen by the select bit
  function automatic logic port_hit(input logic [15:0] addr, input logic color,
                                    input logic [15:0] mono_a,
                                    input logic [15:0] color_a);
    port_hit = (addr == (color ? color_a : mono_a));
  endfunction

  // read value of the register under the index
  function automatic logic [7:0] reg_rd(input logic [6:0] ix);
    case (ix)
      IX_HTOTAL: reg_rd = htotal_r;
      IX_HACT_END: reg_rd = hact_end_r;
      IX_HBLK_START: reg_rd = hblk_start_r;
      IX_HBLK_END: reg_rd = RSVD_ONE | {1'b0, hblk_end_r}; // see [RULE11]
      IX_HSYNC_START: reg_rd = hsync_start_r;
      IX_HSYNC_END: reg_rd = hsync_end_r;
      default: reg_rd = UNMAPPED_RD;
    endcase
  endfunction

  assign idx_hit = port_hit(IO.io_addr, IO.color_sel, IO_IDX_MONO, IO_IDX_COLOR); // see [RULE1]
  assign dat_hit = port_hit(IO.io_addr, IO.color_sel, IO_DAT_MONO, IO_DAT_COLOR); // see [RULE2]
  // index is seven bits, so 0-7 is a plain compare
  assign wr_ok = IO.io_wr && dat_hit && !(IO.protect && idx_r <= IX_PROT_LAST); // see [RULE4]

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idx_r <= IDX_RST;
    end else if (IO.io_wr && idx_hit) begin
      idx_r <= IO.io_wdata[6:0]; // see [RULE3]
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      htotal_r <= HTOTAL_RST;
      hact_end_r <= REG_RST;
      hblk_start_r <= REG_RST;
      hblk_end_r <= REG_RST[6:0];
      hsync_start_r <= REG_RST;
      hsync_end_r <= HSYNC_END_RST;
    end else if (wr_ok) begin
      case (idx_r) // see [RULE2]
        IX_HTOTAL: htotal_r <= IO.io_wdata;
        IX_HACT_END: hact_end_r <= IO.io_wdata;
        IX_HBLK_START: hblk_start_r <= IO.io_wdata;
        IX_HBLK_END: hblk_end_r <= IO.io_wdata[6:0]; // see [RULE11]
        IX_HSYNC_START: hsync_start_r <= IO.io_wdata;
        IX_HSYNC_END: hsync_end_r <= IO.io_wdata;
        default: ;
      endcase
    end
  end

  // every strobe is answered next cycle, even at foreign addresses,
  // so the controller never hangs on a mistyped port
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IO.io_ack <= 1'b0;
      IO.io_rdata <= UNMAPPED_RD;
    end else begin
      IO.io_ack <= IO.io_wr || IO.io_rd;
      if (IO.io_rd) begin
        if (idx_hit) begin
          IO.io_rdata <= {1'b0, idx_r}; // see [RULE3]
        end else if (dat_hit) begin
          IO.io_rdata <= reg_rd(idx_r); // see [RULE21]
        end else begin
          IO.io_rdata <= UNMAPPED_RD;
        end
      end
    end
  end

  // character clock enable
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= 8'h00;
      ce_r <= 1'b0;
    end else if (div_r == DIV_LAST) begin
      div_r <= 8'h00;
      ce_r <= 1'b1;
    end else begin
      div_r <= div_r + 8'h01;
      ce_r <= 1'b0;
    end
  end

  assign cnt_last = {1'b0, htotal_r} + HTOTAL_LAST_BIAS; // see [RULE5]

  // a total lowered below the count still wraps: >= not ==
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 9'h000;
    end else if (ce_r) begin
      if (cnt_r >= cnt_last) begin
        cnt_r <= 9'h000; // see [RULE20]
      end else begin
        cnt_r <= cnt_r + 9'h001;
      end
    end
  end

  // active end inclusive, last char of line never active
  assign de_raw = IO.vactive && (cnt_r <= {1'b0, hact_end_r}) // see [RULE7] [RULE8]
                  && (cnt_r != cnt_last); // see [RULE9]

  // registered like blank and sync, so all three leave the skew stage aligned
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      de_r <= 1'b0;
    end else if (ce_r) begin
      de_r <= de_raw; // see [RULE8]
    end
  end

  assign blk_end6 = {hsync_end_r[BE_MSB_BIT], hblk_end_r[BE_LOW_HI:0]}; // see [RULE14]

  // a start match wins over an end match in the same character
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      blank_r <= 1'b0;
    end else if (ce_r) begin
      if (cnt_r == {1'b0, hblk_start_r}) begin
        blank_r <= 1'b1; // see [RULE10]
      end else if (cnt_r[BE_W-1:0] == blk_end6) begin
        blank_r <= 1'b0; // see [RULE13]
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_r <= 1'b0;
    end else if (ce_r) begin
      if (cnt_r == {1'b0, hsync_start_r}) begin
        sync_r <= 1'b1; // see [RULE16]
      end else if (cnt_r[SE_W-1:0] == hsync_end_r[SE_HI:0]) begin
        sync_r <= 1'b0; // see [RULE19]
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FETCH_EN <= 1'b0;
    end else begin
      FETCH_EN <= (htotal_r != HTOTAL_RST); // see [RULE6]
    end
  end

  // blanking goes through a zero-delay stage to stay aligned
  vgah_dly u_de_skew (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(ce_r),
    .d(de_r),
    .sel(hblk_end_r[SKEW_HI:SKEW_LO]), // see [RULE12]
    .q(HDE)
  );

  vgah_dly u_blank_align (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(ce_r),
    .d(blank_r),
    .sel(2'h0),
    .q(HBLANK)
  );

  vgah_dly u_sync_delay (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(ce_r),
    .d(sync_r),
    .sel(hsync_end_r[SKEW_HI:SKEW_LO]), // see [RULE18]
    .q(HSYNC)
  );
endmodule
`default_nettype wire

// [vgah_host.sv]
// controller end: axi4-lite slave for software, issues i/o cycles to the
// timing device and drives its select, protect and vertical-active levels
// assumes software keeps the programming limits of the timing fields
`timescale 1ns/1ps
`default_nettype none
module vgah_host (
  input wire logic CLK, // system clock
  input wire logic RST_N, // async reset, active low
  vgah_if.host IO, // i/o port toward the device
  input wire logic [7:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output var logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
  input wire logic S_AXI_WVALID, // write data valid
  output var logic S_AXI_WREADY, // write data ready
  output var logic [1:0] S_AXI_BRESP, // write response
  output var logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [7:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output var logic S_AXI_ARREADY, // read address ready
  output var logic [31:0] S_AXI_RDATA, // read data
  output var logic [1:0] S_AXI_RRESP, // read response
  output var logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY // read data ready
);
  import vgah_pkg::*;

  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic start_wr;
  logic start_rd;
  logic [7:0] last_rd_r;
  vgah_io_state_e st_r;

  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  assign do_wr = aw_held_r && w_held_r && !S_AXI_BVALID;
  assign start_wr = do_wr && awaddr_r == HR_WDATA && wstrb_r[0] && st_r == VGAH_IDLE;
  assign start_rd = do_wr && awaddr_r == HR_READ && st_r == VGAH_IDLE;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held_r && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY <= !w_held_r && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awaddr_r == HR_CTRL || awaddr_r == HR_ADDR || awaddr_r == HR_WDATA
                        || awaddr_r == HR_READ || awaddr_r == HR_STAT) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // control levels and target address
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IO.color_sel <= 1'b0;
      IO.protect <= 1'b0;
      IO.vactive <= 1'b0;
      IO.io_addr <= 16'h0000;
    end else if (do_wr && awaddr_r == HR_CTRL && wstrb_r[0]) begin
      IO.color_sel <= wdata_r[CTL_COLOR];
      IO.protect <= wdata_r[CTL_PROT];
      IO.vactive <= wdata_r[CTL_VACT];
    end else if (do_wr && awaddr_r == HR_ADDR) begin
      IO.io_addr <= {lane(IO.io_addr[15:8], wdata_r[15:8], wstrb_r[1]),
                     lane(IO.io_addr[7:0], wdata_r[7:0], wstrb_r[0])};
    end
  end

  // one i/o cycle at a time; a start while busy is dropped
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= VGAH_IDLE;
      IO.io_wr <= 1'b0;
      IO.io_rd <= 1'b0;
      IO.io_wdata <= 8'h00;
      last_rd_r <= 8'h00;
    end else begin
      case (st_r)
        VGAH_IDLE: begin
          if (start_wr || start_rd) begin
            IO.io_wr <= start_wr;
            IO.io_rd <= start_rd;
            IO.io_wdata <= wdata_r[7:0];
            st_r <= VGAH_REQ;
          end
        end
        VGAH_REQ: begin
          IO.io_wr <= 1'b0;
          IO.io_rd <= 1'b0;
          st_r <= VGAH_WAIT;
        end
        VGAH_WAIT: begin
          if (IO.io_ack) begin
            last_rd_r <= IO.io_rdata;
            st_r <= VGAH_IDLE;
          end
        end
        default: st_r <= VGAH_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= RESP_OKAY;
        case (S_AXI_ARADDR)
          HR_CTRL: S_AXI_RDATA <= {29'h0, IO.vactive, IO.protect, IO.color_sel};
          HR_ADDR: S_AXI_RDATA <= {16'h0000, IO.io_addr};
          HR_STAT: S_AXI_RDATA <= {23'h0, st_r != VGAH_IDLE, last_rd_r};
          HR_WDATA, HR_READ: S_AXI_RDATA <= 32'h0000_0000;
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [vgah_dummy_unused.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [vgah_asserts.sv]
// checker for the i/o port between controller and timing device
// assumes one clock and a character divider of one in the bench
`timescale 1ns/1ps
`default_nettype none
module vgah_asserts (
  input wire logic CLK, // system clock
  input wire logic RST_N, // async reset, active low
  input wire logic [15:0] io_addr, // port address
  input wire logic io_wr, // write strobe
  input wire logic io_rd, // read strobe
  input wire logic [7:0] io_rdata, // read data
  input wire logic io_ack, // cycle acknowledge
  input wire logic color_sel, // emulation select
  input wire logic vactive, // vertical active line
  input wire logic HDE, // display enable
  input wire logic FETCH_EN // display fetch allowed
);
  import vgah_pkg::*;
  logic idx_a;
  logic own_a;
  logic [3:0] since_wr_r;
  logic [8:0] hde_run_r;
  assign idx_a = io_addr == (color_sel ? IO_IDX_COLOR : IO_IDX_MONO);
  assign own_a = idx_a || io_addr == (color_sel ? IO_DAT_COLOR : IO_DAT_MONO);
  // saturating counters keep long runs cheap for the tools
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) since_wr_r <= 4'hF;
    else if (io_wr) since_wr_r <= 4'h0;
    else if (since_wr_r != 4'hF) since_wr_r <= since_wr_r + 4'h1;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) hde_run_r <= 9'h000;
    else if (!HDE) hde_run_r <= 9'h000;
    else if (hde_run_r != 9'h1FF) hde_run_r <= hde_run_r + 9'h001;
  end
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ack_after_strobe: assert property (io_wr || io_rd |=> io_ack)
    else $error("no acknowledge after strobe");
  a_ack_one_cycle: assert property (io_ack |=> !io_ack)
    else $error("acknowledge longer than one cycle");
  a_ack_has_cause: assert property (io_ack |-> $past(io_wr) || $past(io_rd))
    else $error("acknowledge without strobe");
  a_index_top_zero: assert property (io_ack && $past(io_rd) && $past(idx_a) |-> !io_rdata[7])
    else $error("index top bit read as one");
  a_foreign_reads_zero: assert property (io_ack && $past(io_rd) && !$past(own_a) |-> io_rdata == 8'h00)
    else $error("foreign port returned data");
  a_rdata_holds: assert property (!io_ack |-> $stable(io_rdata))
    else $error("read data moved without acknowledge");
  a_hde_needs_vact: assert property (!vactive [*8] |-> !HDE)
    else $error("display enable outside vertical active");
  a_fetch_has_cause: assert property ($changed(FETCH_EN) |-> since_wr_r < 4'h6)
    else $error("fetch enable moved without a write");
  a_hde_drops: assert property (hde_run_r <= 9'd262)
    else $error("display enable never drops");
  c_write: cover property (io_wr ##1 io_ack);
  c_read: cover property (io_rd ##1 io_ack);
  c_hde: cover property ($rose(HDE));
  c_fetch: cover property ($rose(FETCH_EN));
endmodule
`default_nettype wire

// [vgah_bench.sv]
// bench: controller and timing device joined, driven over axi4-lite
// assumes a character clock of one system clock
`timescale 1ns/1ps
`default_nettype none
module vgah_bench;
  import vgah_pkg::*;
  logic clk;
  logic rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bred = 1'b0, arv = 1'b0, rred = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic awr, wr, bv, arr, rv, hde, hbl, hsy, fen;
  logic [1:0] br, rr;
  logic col = 1'b0, prot = 1'b0, vact = 1'b0;
  logic [2:0] prv = 3'b000, now_s;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int rise_t[3];
  int fall_t[3];
  vgah_if u_vgah_if();
  vgah_host u_vgah_host (.CLK(clk), .RST_N(rst_n), .IO(u_vgah_if), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bred), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rred));
  vgah_dev #(.CHAR_DIV(1)) u_vgah_dev (.CLK(clk), .RST_N(rst_n), .IO(u_vgah_if),
    .HDE(hde), .HBLANK(hbl), .HSYNC(hsy), .FETCH_EN(fen));
  vgah_asserts u_vgah_asserts (.CLK(clk), .RST_N(rst_n), .io_addr(u_vgah_if.io_addr),
    .io_wr(u_vgah_if.io_wr), .io_rd(u_vgah_if.io_rd), .io_rdata(u_vgah_if.io_rdata),
    .io_ack(u_vgah_if.io_ack), .color_sel(u_vgah_if.color_sel),
    .vactive(u_vgah_if.vactive), .HDE(hde), .FETCH_EN(fen));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  assign now_s = {hsy, hbl, hde};
  // edge times of enable, blank and sync in system clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prv <= now_s;
    for (int i = 0; i < 3; i++) begin
      if (now_s[i] && !prv[i]) rise_t[i] <= cyc;
      if (!now_s[i] && prv[i]) fall_t[i] <= cyc;
    end
  end
  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bred <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv && bred) begin
        r = br;
        bred <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rred <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && rred) begin
        d = rd;
        r = rr;
        rred <= 1'b0;
        break;
      end
    end
  endtask
  function automatic logic [15:0] port(input logic c, input logic dat);
    return c ? (dat ? IO_DAT_COLOR : IO_IDX_COLOR) : (dat ? IO_DAT_MONO : IO_IDX_MONO);
  endfunction
  // one byte cycle; waits for busy to clear so the next request is not dropped
  task automatic io_op(input logic [15:0] a, input logic rdn, input logic [7:0] d,
                       output logic [7:0] q);
    logic [1:0] r;
    logic [31:0] s;
    axi_wr(HR_ADDR, {16'h0, a}, r);
    axi_wr(rdn ? HR_READ : HR_WDATA, {24'h0, d}, r);
    s = 32'h100;
    while (s[ST_BUSY]) axi_rd(HR_STAT, s, r);
    q = s[7:0];
  endtask
  task automatic reg_wr(input logic [6:0] ix, input logic [7:0] d);
    logic [7:0] q;
    io_op(port(col, 1'b0), 1'b0, {1'b0, ix}, q);
    io_op(port(col, 1'b1), 1'b0, d, q);
  endtask
  task automatic reg_rd(input logic [6:0] ix, output logic [7:0] q);
    io_op(port(col, 1'b0), 1'b0, {1'b0, ix}, q);
    io_op(port(col, 1'b1), 1'b1, 8'h00, q);
  endtask
  task automatic set_ctrl();
    logic [31:0] v;
    logic [31:0] s;
    logic [1:0] r;
    v = 32'h0;
    v[CTL_COLOR] = col;
    v[CTL_PROT] = prot;
    v[CTL_VACT] = vact;
    axi_wr(HR_CTRL, v, r);
    axi_rd(HR_CTRL, s, r);
    chk("ctrl_read", v, s);
  endtask
  task automatic t_reset();
    logic [7:0] q;
    logic [31:0] s;
    logic [1:0] r;
    reg_rd(IX_HTOTAL, q);
    chk("total_reset", HTOTAL_RST, q);
    reg_rd(IX_HBLK_END, q);
    chk("blank_end_reset", RSVD_ONE, q);
    reg_rd(IX_HSYNC_END, q);
    chk("sync_end_reset", HSYNC_END_RST, q);
    chk("fetch_off", 1'b0, fen);
    axi_rd(8'h40, s, r);
    chk("unmapped_read", RESP_SLVERR, r);
    axi_wr(8'h44, 32'h1, r);
    chk("unmapped_write", RESP_SLVERR, r);
  endtask
  task automatic t_regs();
    logic [7:0] q;
    io_op(port(col, 1'b0), 1'b0, 8'hFF, q);
    io_op(port(col, 1'b0), 1'b1, 8'h00, q);
    chk("index_read", 8'h7F, q);
    reg_wr(IX_HBLK_END, 8'h15);
    reg_rd(IX_HBLK_END, q);
    chk("blank_end_read", 8'h95, q);
  endtask
  task automatic t_ports(input logic c);
    logic [7:0] q;
    col = c;
    set_ctrl();
    reg_wr(IX_HSYNC_START, {7'h18, c});
    io_op(port(~c, 1'b1), 1'b0, 8'hEE, q);
    io_op(port(~c, 1'b0), 1'b0, 8'h02, q);
    io_op(port(~c, 1'b1), 1'b1, 8'h00, q);
    chk("foreign_data", 8'h00, q);
    io_op(port(c, 1'b1), 1'b1, 8'h00, q);
    chk("own_data", {7'h18, c}, q);
  endtask
  task automatic t_protect();
    logic [7:0] q;
    prot = 1'b1;
    set_ctrl();
    reg_wr(IX_HTOTAL, 8'h33);
    reg_rd(IX_HTOTAL, q);
    chk("protected", HTOTAL_RST, q);
    prot = 1'b0;
    set_ctrl();
    reg_wr(IX_HTOTAL, 8'h33);
    reg_rd(IX_HTOTAL, q);
    chk("unprotected", 8'h33, q);
    chk("fetch_on", 1'b1, fen);
  endtask
  task automatic next_line(output int t);
    int old;
    old = rise_t[0];
    while (rise_t[0] == old) @(negedge clk);
    t = rise_t[0];
  endtask
  // line of 24 chars: blank 10..18, sync 12..15, skew and delay both k
  task automatic t_line(input logic [1:0] k, input logic [7:0] ae, input int hi);
    int r1, r2;
    reg_wr(IX_HACT_END, ae);
    reg_wr(IX_HBLK_END, {1'b0, k, 5'h12});
    reg_wr(IX_HSYNC_END, {1'b0, k, 5'h0F});
    next_line(r1);
    next_line(r1);
    next_line(r2);
    chk("line_len", 24, r2 - r1);
    chk("active_len", hi, fall_t[0] - r1);
    chk("blank_len", 8, fall_t[1] - rise_t[1]);
    chk("sync_len", 3, fall_t[2] - rise_t[2]);
    chk("sync_pos", 2 + k, rise_t[2] - rise_t[1]);
    if (hi == 6) begin
      chk("blank_pos", 10 - k, rise_t[1] - r1);
      chk("enable_end", 4 - k, rise_t[1] - fall_t[0]);
    end
  endtask
  task automatic t_hold();
    int f;
    reg_wr(IX_HSYNC_END, 8'h8F);
    repeat (24) @(negedge clk);
    f = fall_t[1];
    repeat (48) @(negedge clk);
    chk("blank_hold", f, fall_t[1]);
    vact = 1'b0;
    set_ctrl();
    repeat (8) @(negedge clk);
    f = rise_t[0];
    repeat (48) @(negedge clk);
    chk("enable_off", f, rise_t[0]);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_ports(1'b0);
    t_ports(1'b1);
    t_protect();
    reg_wr(IX_HTOTAL, 8'h13);
    reg_wr(IX_HBLK_START, 8'h0A);
    reg_wr(IX_HSYNC_START, 8'h0C);
    vact = 1'b1;
    set_ctrl();
    for (int k = 0; k < 4; k++) t_line(k[1:0], 8'h05, 6);
    t_line(2'b00, 8'hFF, 23);
    t_hold();
    final_report();
  end
  // cut a hang well past the few thousand cycles the tests take
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
